/* File: common/ptm_pkg.sv */
package ptm_pkg;

  // ****************************************************************
  // Register map, word aligned on the AXI4-Lite bus
  // ****************************************************************
  localparam logic [5:0] ADDR_CTRL0 = 6'h00;
  localparam logic [5:0] ADDR_CTRL1 = 6'h04;
  localparam logic [5:0] ADDR_CNT_LO = 6'h08;
  localparam logic [5:0] ADDR_CNT_HI = 6'h0C;
  localparam logic [5:0] ADDR_DUTY_LO = 6'h10;
  localparam logic [5:0] ADDR_DUTY_HI = 6'h14;
  localparam logic [5:0] ADDR_PER_LO = 6'h18;
  localparam logic [5:0] ADDR_PER_HI = 6'h1C;
  localparam logic [5:0] ADDR_FLAGS = 6'h20;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int PAUSE_BIT = 7;
  localparam int CLKSEL_LSB = 4;
  localparam int RUN_BIT = 3;
  localparam int MODE_LSB = 6;
  localparam int PINFN_LSB = 4;
  localparam int INIT_BIT = 3;
  localparam int INV_BIT = 2;
  localparam int CAPSRC_BIT = 1;
  localparam int CLRSRC_BIT = 0;
  localparam logic [7:0] CTRL0_WMASK = 8'hF8;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ****************************************************************
  // Encodings
  // ****************************************************************
  localparam logic [1:0] MODE_CMP = 2'b00;
  localparam logic [1:0] MODE_CAP = 2'b01;
  localparam logic [1:0] MODE_PWM = 2'b10;
  localparam logic [1:0] MODE_TMR = 2'b11;
  localparam logic [2:0] CK_SYS4 = 3'b000;
  localparam logic [2:0] CK_SYS = 3'b001;
  localparam logic [2:0] CK_H16 = 3'b010;
  localparam logic [2:0] CK_H64 = 3'b011;
  localparam logic [2:0] CK_SUB0 = 3'b100;
  localparam logic [2:0] CK_SUB1 = 3'b101;
  localparam logic [2:0] CK_EXT_RISE = 3'b110;
  localparam logic [1:0] FN_00 = 2'b00;
  localparam logic [1:0] FN_01 = 2'b01;
  localparam logic [1:0] FN_10 = 2'b10;
  localparam logic [1:0] FN_11 = 2'b11;

  // ****************************************************************
  // Bundled signals
  // ****************************************************************
  typedef struct packed {
    logic pause;
    logic [2:0] clock_sel;
    logic run;
  } ptm_ctrl0_t;

  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] pin_fn;
    logic init_level;
    logic invert;
    logic cap_src;
    logic clr_src;
  } ptm_ctrl1_t;

endpackage

/* File: test/ptm_core_bench.sv */
`timescale 1ns/1ps
// ****************************************************************
// Bus tasks, stimulus and checks
// ****************************************************************
module ptm_core_bench;
  logic clock_in = 1'h0;
  logic rst_in = 1'h1;
  logic high_clk_tick_in = 1'h0;
  logic external_clock_pin_in = 1'h0;
  logic capture_input_pin_in = 1'h0;
  logic timer_output_pin_out;
  logic timer_output_pin_oe_out;
  logic [5:0] s_axi_awaddr = 6'h00;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'h0;
  logic [5:0] s_axi_araddr = 6'h00;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'h0;
  int seed = 6;
  int error_cnt = 0;
  int n_compared = 0;
  logic [1:0] wresp;

  ptm_core #(.INSTANCE(2), .SUB_DIV(4)) dut (
    .clock_in, .rst_in, .high_clk_tick_in, .external_clock_pin_in, .capture_input_pin_in,
    .timer_output_pin_out, .timer_output_pin_oe_out, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  always #2.5 clock_in = ~clock_in;

  always begin
    repeat (2) @(posedge clock_in);
    high_clk_tick_in <= ~high_clk_tick_in;
  end

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock_in);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clock_in);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    wresp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock_in);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clock_in);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  task automatic c0(input logic [7:0] v);
    wr(ptm_pkg::ADDR_CTRL0, v);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic ok(input logic c);
    chk({31'h0, c}, 32'h0000_0001);
  endtask

  task automatic rchk(input logic [5:0] a, input logic [7:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, {24'h00_0000, exp});
  endtask

  function automatic logic exp_pin(input logic [1:0] fn, input logic init);
    case (fn)
      2'h1: return 1'h0;
      2'h2: return 1'h1;
      2'h3: return ~init;
      default: return init;
    endcase
  endfunction

  // The high clock input toggles every two system clocks, so one high period is four.
  function automatic int tick_div(input int k);
    case (k)
      2: return 64;
      3: return 256;
      default: return 4;
    endcase
  endfunction

  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // A hung bus handshake would otherwise stall the run for ever.
  initial begin
    #100us;
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    close_out();
  end

  initial begin
    logic [31:0] d;
    logic [31:0] v;
    logic [1:0] r;
    logic [7:0] x;
    repeat (16) @(posedge clock_in);
    rst_in <= 1'h0;
    for (int a = 0; a <= 32; a += 4) begin
      rchk(6'(a), 8'h00);
    end
    for (int a = 16; a <= 28; a += 4) begin
      x = 8'($random(seed));
      wr(6'(a), x);
      rchk(6'(a), x);
    end
    x = 8'($random(seed));
    c0(x | 8'h07);
    rchk(ptm_pkg::ADDR_CTRL0, x & 8'hf8);
    c0(8'h00);
    rd(ptm_pkg::ADDR_CNT_LO, v, r);
    wr(ptm_pkg::ADDR_CNT_LO, ~v[7:0]);
    chk(32'(wresp), 32'(ptm_pkg::RESP_OKAY));
    rchk(ptm_pkg::ADDR_CNT_LO, v[7:0]);
    rd(6'h24, d, r);
    chk(32'(r), 32'(ptm_pkg::RESP_SLVERR));
    wr(6'h24, 8'hff);
    chk(32'(wresp), 32'(ptm_pkg::RESP_SLVERR));
    rd(6'h06, d, r);
    chk(32'(r), 32'(ptm_pkg::RESP_SLVERR));
    $display("test register access done");
    wr(ptm_pkg::ADDR_DUTY_HI, 8'h00);
    wr(ptm_pkg::ADDR_PER_HI, 8'h00);
    wr(ptm_pkg::ADDR_DUTY_LO, 8'h05);
    wr(ptm_pkg::ADDR_PER_LO, 8'h0a);
    for (int c = 0; c < 2; c++) begin
      c0(8'h00);
      wr(ptm_pkg::ADDR_CTRL1, {7'h60, c[0]});
      rchk(ptm_pkg::ADDR_CTRL1, {7'h60, c[0]});
      c0(8'h18);
      wr(ptm_pkg::ADDR_FLAGS, 8'h03);
      repeat (6) begin
        repeat (4'($random(seed))) @(posedge clock_in);
        rd(ptm_pkg::ADDR_CNT_LO, d, r);
        ok(d < (c ? 32'h0000_0005 : 32'h0000_000a));
      end
      rchk(ptm_pkg::ADDR_FLAGS, c ? 8'h01 : 8'h03);
    end
    c0(8'h00);
    wr(ptm_pkg::ADDR_CTRL1, 8'hc0);
    wr(ptm_pkg::ADDR_PER_LO, 8'h00);
    c0(8'h18);
    repeat (150) @(posedge clock_in);
    c0(8'h98);
    rd(ptm_pkg::ADDR_CNT_LO, d, r);
    ok(d > 32'h0000_0090);
    repeat (20) @(posedge clock_in);
    rchk(ptm_pkg::ADDR_CNT_LO, d[7:0]);
    c0(8'h18);
    rd(ptm_pkg::ADDR_CNT_LO, v, r);
    ok(v > d && v < d + 32'h0000_0010);
    c0(8'h10);
    rd(ptm_pkg::ADDR_CNT_LO, d, r);
    repeat (20) @(posedge clock_in);
    rchk(ptm_pkg::ADDR_CNT_LO, d[7:0]);
    c0(8'h18);
    rd(ptm_pkg::ADDR_CNT_LO, v, r);
    ok(v < 32'h0000_0010);
    c0(8'h00);
    c0(8'h08);
    repeat (200) @(posedge clock_in);
    c0(8'h88);
    rd(ptm_pkg::ADDR_CNT_LO, d, r);
    ok(d >= 32'h0000_0032 && d <= 32'h0000_0036);
    for (int k = 2; k < 6; k++) begin
      c0(8'h00);
      c0({1'h0, 3'(k), 4'h8});
      repeat (200) @(posedge clock_in);
      c0({1'h1, 3'(k), 4'h8});
      rd(ptm_pkg::ADDR_CNT_LO, d, r);
      ok((int'(d) + 1) * tick_div(k) >= 203 && (int'(d) - 1) * tick_div(k) <= 203);
    end
    for (int e = 0; e < 2; e++) begin
      c0(8'h60);
      c0(e ? 8'h78 : 8'h68);
      repeat (7) begin
        repeat (4) @(posedge clock_in);
        external_clock_pin_in <= 1'h1;
        repeat (4) @(posedge clock_in);
        external_clock_pin_in <= 1'h0;
      end
      repeat (8) @(posedge clock_in);
      rchk(ptm_pkg::ADDR_CNT_LO, 8'h07);
    end
    $display("test counter done");
    wr(ptm_pkg::ADDR_DUTY_LO, 8'h64);
    for (int i = 0; i < 8; i++) begin
      c0(8'h00);
      wr(ptm_pkg::ADDR_CTRL1, {2'h0, 2'(i), i[2], 3'h1});
      c0(8'h08);
      repeat (4) @(negedge clock_in);
      chk(32'(timer_output_pin_out), 32'(i[2]));
      repeat (600) @(negedge clock_in);
      chk(32'(timer_output_pin_out), 32'(exp_pin(2'(i), i[2])));
    end
    wr(ptm_pkg::ADDR_CTRL1, 8'h3d);
    repeat (4) @(negedge clock_in);
    chk(32'(timer_output_pin_out), 32'h0000_0001);
    rchk(ptm_pkg::ADDR_CTRL1, 8'h3d);
    for (int j = 0; j < 2; j++) begin
      c0(8'h00);
      wr(ptm_pkg::ADDR_CTRL1, {3'h4, j[0], 4'h8});
      c0(8'h08);
      repeat (4) @(negedge clock_in);
      chk(32'(timer_output_pin_out), 32'(j[0]));
    end
    wr(ptm_pkg::ADDR_PER_LO, 8'hc8);
    c0(8'h00);
    wr(ptm_pkg::ADDR_CTRL1, 8'ha8);
    c0(8'h08);
    repeat (200) @(negedge clock_in);
    chk(32'(timer_output_pin_out), 32'h0000_0001);
    repeat (400) @(negedge clock_in);
    chk(32'(timer_output_pin_out), 32'h0000_0000);
    c0(8'h00);
    wr(ptm_pkg::ADDR_CTRL1, 8'hb8);
    c0(8'h08);
    repeat (4) @(negedge clock_in);
    chk(32'(timer_output_pin_out), 32'h0000_0001);
    repeat (600) @(negedge clock_in);
    chk(32'(timer_output_pin_out), 32'h0000_0000);
    rchk(ptm_pkg::ADDR_CTRL0, 8'h00);
    $display("test output pin done");
    c0(8'h00);
    wr(ptm_pkg::ADDR_CTRL1, 8'h40);
    c0(8'h18);
    repeat (9) @(posedge clock_in);
    c0(8'h98);
    rd(ptm_pkg::ADDR_CNT_LO, d, r);
    wr(ptm_pkg::ADDR_FLAGS, 8'h03);
    capture_input_pin_in <= 1'h1;
    repeat (8) @(posedge clock_in);
    rchk(ptm_pkg::ADDR_DUTY_LO, d[7:0]);
    rchk(ptm_pkg::ADDR_FLAGS, 8'h01);
    wr(ptm_pkg::ADDR_CTRL1, 8'h52);
    wr(ptm_pkg::ADDR_DUTY_LO, 8'h00);
    capture_input_pin_in <= 1'h0;
    repeat (8) @(posedge clock_in);
    rchk(ptm_pkg::ADDR_DUTY_LO, 8'h00);
    external_clock_pin_in <= 1'h1;
    repeat (8) @(posedge clock_in);
    external_clock_pin_in <= 1'h0;
    repeat (8) @(posedge clock_in);
    rchk(ptm_pkg::ADDR_DUTY_LO, d[7:0]);
    $display("test capture done");
    close_out();
  end
endmodule

bind ptm_core ptm_core_monitor mon (.clock_in, .rst_in, .timer_output_pin_oe_out, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid);

/* File: test/ptm_core_monitor.sv */
`timescale 1ns/1ps
// ****************************************************************
// Port checks on the register bus and the pin enable
// ****************************************************************
module ptm_core_monitor (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic timer_output_pin_oe_out,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid
);
  logic [5:0] ar_addr_r;
  logic bad_addr;

  // Read data is judged by the address it answers, so that address is kept.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ar_addr_r <= 6'h00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      ar_addr_r <= s_axi_araddr;
    end
  end
  assign bad_addr = (ar_addr_r[1:0] != 2'h0) || (ar_addr_r > ptm_pkg::ADDR_FLAGS);

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);

  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
    else $error("write got no response in time");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while a response is pending");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:3] s_axi_rvalid)
    else $error("read got no data in time");
  a_read_busy: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready)
    else $error("second read accepted while one is pending");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("read data above the byte not zero");
  a_ctrl0_low: assert property (
    s_axi_rvalid && ar_addr_r == ptm_pkg::ADDR_CTRL0 |-> s_axi_rdata[2:0] == 3'h0)
    else $error("unused control bits read nonzero");
  a_oe_by_mode: assert property (
    s_axi_rvalid && ar_addr_r == ptm_pkg::ADDR_CTRL1 |-> timer_output_pin_oe_out == !s_axi_rdata[6])
    else $error("pin enable disagrees with mode");
  a_bad_slverr: assert property (s_axi_rvalid && bad_addr |-> s_axi_rresp == ptm_pkg::RESP_SLVERR)
    else $error("unmapped read not refused");
  a_good_okay: assert property (s_axi_rvalid && !bad_addr |-> s_axi_rresp == ptm_pkg::RESP_OKAY)
    else $error("mapped read refused");
endmodule

/* File: verilog/ptm_core.sv */
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
// Functional notes
// - Up counter, 10 bits on instances 0-1, 16 bits on 2-3, selected clock.
// - Comparators A and P compare full counter with duty and period values.
// - Software clears counter only via run rising edge; hardware clears on overflow/match.
// - Pause bit holds count; clearing it resumes from held value.
// - Clock select picks sys/4, sys, high/16, high/64, sub, external edges (external edges give no count on instance 1).
// - Run low stops counting keeping count; run rising edge zeroes counter.
// - Run rising edge returns output to initial level in output modes.
// - Mode field: compare, capture (absent on instance 1), PWM/single pulse, timer/counter.
// - Compare mode match A: none, low, high, toggle.
// - PWM mode: force inactive, force active, PWM, single pulse.
// - Capture edge: rising, falling, both, disabled.
// - Requested level equal to initial level shows no change on match.
// - Initial-level bit sets initial, active, or pulse-start level.
// - Invert bit inverts output pin; no effect in timer/counter mode.
// - Capture source: 0 capture pin, 1 external clock pin.
// - Clear source: 0 comparator P match, 1 comparator A match.
// - Control registers reset to zero; control 0 bits 2-0 read zero.
// - Counter read-only pair; duty and period read/write pairs.
// - Period zero with P clear means overflow wrap at full width.
// - Compare mode output changes only on A match flag or run rising edge, never P.
module ptm_core #(
  parameter int INSTANCE = 2,
  parameter int SUB_DIV = 512
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic high_clk_tick_in,
  input wire logic external_clock_pin_in,
  input wire logic capture_input_pin_in,
  output logic timer_output_pin_out,
  output logic timer_output_pin_oe_out,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int W = (INSTANCE < 2) ? 10 : 16;
  localparam logic [W-1:0] CNT_ZERO = '0;
  localparam logic [W-1:0] CNT_ONE = W'(1);
  localparam logic [W-1:0] CNT_MAX = '1;
  localparam logic HAS_EXT = (INSTANCE != 1);

  // ****************************************************************
  // Registers
  // ****************************************************************
  ptm_pkg::ptm_ctrl0_t c0_r;
  ptm_pkg::ptm_ctrl1_t c1_r;
  logic [W-1:0] cnt_r, duty_r, per_r;
  logic flag_a_r, flag_p_r, pin_r, run_d_r;
  logic [1:0] ext_sync_r, cap_sync_r, hck_sync_r;
  logic ext_d_r, cap_d_r, hck_d_r;
  logic [1:0] div4_r;
  logic [5:0] hdiv_r;
  logic [15:0] sub_r;
  logic [5:0] aw_addr_r, ar_addr_r;
  logic aw_ok_r, w_ok_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ext_sync_r <= 2'b00;
      cap_sync_r <= 2'b00;
      hck_sync_r <= 2'b00;
      ext_d_r <= 1'b0;
      cap_d_r <= 1'b0;
      hck_d_r <= 1'b0;
    end else begin
      ext_sync_r <= {ext_sync_r[0], external_clock_pin_in};
      cap_sync_r <= {cap_sync_r[0], capture_input_pin_in};
      hck_sync_r <= {hck_sync_r[0], high_clk_tick_in};
      ext_d_r <= ext_sync_r[1];
      cap_d_r <= cap_sync_r[1];
      hck_d_r <= hck_sync_r[1];
    end
  end

  wire ext_rise = ext_sync_r[1] & ~ext_d_r;
  wire ext_fall = ~ext_sync_r[1] & ext_d_r;
  wire hck_rise = hck_sync_r[1] & ~hck_d_r;

  // ****************************************************************
  // Count clock selection
  // ****************************************************************
  // The high and sub clocks are not separate domains here: the high clock
  // arrives as a synchronised tick and the sub clock is a divided system tick.
  wire tick_sys4 = (div4_r == 2'b11);
  wire tick_h16 = hck_rise & (hdiv_r[3:0] == 4'hF);
  wire tick_h64 = hck_rise & (hdiv_r == 6'h3F);
  wire tick_sub = (sub_r == 16'(SUB_DIV - 1));
  logic count_tick;
  always_comb begin
    if (c0_r.clock_sel == ptm_pkg::CK_SYS4) begin
      count_tick = tick_sys4;
    end else if (c0_r.clock_sel == ptm_pkg::CK_SYS) begin
      count_tick = 1'b1;
    end else if (c0_r.clock_sel == ptm_pkg::CK_H16) begin
      count_tick = tick_h16;
    end else if (c0_r.clock_sel == ptm_pkg::CK_H64) begin
      count_tick = tick_h64;
    end else if (c0_r.clock_sel == ptm_pkg::CK_SUB0 || c0_r.clock_sel == ptm_pkg::CK_SUB1) begin
      count_tick = tick_sub;
    end else if (c0_r.clock_sel == ptm_pkg::CK_EXT_RISE) begin
      count_tick = HAS_EXT & ext_rise;
    end else begin
      count_tick = HAS_EXT & ext_fall;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      div4_r <= 2'b00;
      hdiv_r <= 6'h00;
      sub_r <= 16'h0000;
    end else begin
      div4_r <= div4_r + 2'b01;
      hdiv_r <= hdiv_r + {5'h00, hck_rise};
      sub_r <= tick_sub ? 16'h0000 : sub_r + 16'h0001;
    end
  end

  // ****************************************************************
  // Counter, comparators and events
  // ****************************************************************
  wire run_rise = c0_r.run & ~run_d_r;
  wire counting = c0_r.run & ~c0_r.pause & count_tick;
  wire mode_cmp = (c1_r.mode == ptm_pkg::MODE_CMP);
  wire mode_cap = (c1_r.mode == ptm_pkg::MODE_CAP) & HAS_EXT;
  wire mode_pwm = (c1_r.mode == ptm_pkg::MODE_PWM);
  wire mode_tmr = (c1_r.mode == ptm_pkg::MODE_TMR);
  wire single = mode_pwm & (c1_r.pin_fn == ptm_pkg::FN_11);
  wire [W-1:0] cnt_inc = cnt_r + CNT_ONE;
  wire match_a = counting & (cnt_inc == duty_r) & (duty_r != CNT_ZERO);
  wire match_p = counting & (cnt_inc == per_r);
  wire wrap = counting & (cnt_r == CNT_MAX);
  // Single pulse and PWM ignore the clear-source bit; capture uses P only.
  wire clr_by_a = (mode_cmp | mode_tmr) ? c1_r.clr_src : single;
  wire evt_a = match_a & ~mode_cap;
  wire evt_p = match_p & ~(clr_by_a & (mode_cmp | mode_tmr)) & ~single;
  wire clr_evt = clr_by_a ? evt_a : evt_p;
  wire cap_pin = c1_r.cap_src ? ext_sync_r[1] : cap_sync_r[1];
  wire cap_prev = c1_r.cap_src ? ext_d_r : cap_d_r;
  wire cap_rise = cap_pin & ~cap_prev;
  wire cap_fall = ~cap_pin & cap_prev;
  logic cap_evt;
  always_comb begin
    case (c1_r.pin_fn)
      ptm_pkg::FN_00: cap_evt = cap_rise;
      ptm_pkg::FN_01: cap_evt = cap_fall;
      ptm_pkg::FN_10: cap_evt = cap_rise | cap_fall;
      default: cap_evt = 1'b0;
    endcase
  end
  wire capture = mode_cap & c0_r.run & cap_evt;

  logic [W-1:0] cnt_nxt;
  always_comb begin
    if (run_rise) begin
      cnt_nxt = CNT_ZERO;
    end else if (clr_evt) begin
      cnt_nxt = CNT_ZERO;
    end else if (counting) begin
      cnt_nxt = cnt_inc;
    end else begin
      cnt_nxt = cnt_r;
    end
  end

  // ****************************************************************
  // Output pin
  // ****************************************************************
  logic pin_nxt;
  logic match_level;
  always_comb begin
    case (c1_r.pin_fn)
      ptm_pkg::FN_01: match_level = 1'b0;
      ptm_pkg::FN_10: match_level = 1'b1;
      ptm_pkg::FN_11: match_level = ~pin_r;
      default: match_level = pin_r;
    endcase
  end
  always_comb begin
    pin_nxt = pin_r;
    if (run_rise) begin
      pin_nxt = c1_r.init_level;
    end else if (mode_cmp & evt_a) begin
      pin_nxt = match_level;
    end else if (mode_pwm & ~single & c0_r.run) begin
      if (c1_r.pin_fn == ptm_pkg::FN_00) begin
        pin_nxt = ~c1_r.init_level;
      end else if (c1_r.pin_fn == ptm_pkg::FN_01) begin
        pin_nxt = c1_r.init_level;
      end else if (evt_p) begin
        pin_nxt = c1_r.init_level;
      end else if (evt_a) begin
        pin_nxt = ~c1_r.init_level;
      end
    end else if (single & evt_a) begin
      pin_nxt = ~c1_r.init_level;
    end
  end
  assign timer_output_pin_out = pin_r ^ c1_r.invert;
  assign timer_output_pin_oe_out = ~mode_tmr & ~mode_cap;

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  assign s_axi_awready = ~aw_ok_r & ~s_axi_bvalid;
  assign s_axi_wready = ~w_ok_r & ~s_axi_bvalid;
  wire do_write = aw_ok_r & w_ok_r;
  wire [7:0] wb = wdata_r[7:0];
  wire wen = do_write & wstrb_r[0];
  wire wr_c0 = wen & (aw_addr_r == ptm_pkg::ADDR_CTRL0);
  wire wr_c1 = wen & (aw_addr_r == ptm_pkg::ADDR_CTRL1);
  wire wr_dl = wen & (aw_addr_r == ptm_pkg::ADDR_DUTY_LO);
  wire wr_dh = wen & (aw_addr_r == ptm_pkg::ADDR_DUTY_HI);
  wire wr_pl = wen & (aw_addr_r == ptm_pkg::ADDR_PER_LO);
  wire wr_ph = wen & (aw_addr_r == ptm_pkg::ADDR_PER_HI);
  wire wr_fl = wen & (aw_addr_r == ptm_pkg::ADDR_FLAGS);
  wire [15:0] whi = {wb, 8'h00};
  wire aw_mapped = (aw_addr_r <= ptm_pkg::ADDR_FLAGS) & (aw_addr_r[1:0] == 2'b00);

  // Capture loads the duty register; a capture wins over a software write.
  logic [W-1:0] duty_nxt;
  always_comb begin
    duty_nxt = duty_r;
    if (capture) begin
      duty_nxt = cnt_r;
    end else if (wr_dl) begin
      duty_nxt = {duty_r[W-1:8], wb};
    end else if (wr_dh) begin
      duty_nxt = W'(whi) | W'(duty_r[7:0]);
    end
  end
  wire [W-1:0] per_nxt = wr_pl ? {per_r[W-1:8], wb} :
                         wr_ph ? ((per_r & W'(16'h00FF)) | W'(whi)) : per_r;

  wire [15:0] cnt16 = 16'(cnt_r);
  wire [15:0] duty16 = 16'(duty_r);
  wire [15:0] per16 = 16'(per_r);
  logic [7:0] rbyte;
  logic rerr;
  always_comb begin
    rerr = 1'b0;
    if (ar_addr_r == ptm_pkg::ADDR_CTRL0) begin
      rbyte = 8'(c0_r) << ptm_pkg::RUN_BIT;
    end else if (ar_addr_r == ptm_pkg::ADDR_CTRL1) begin
      rbyte = c1_r;
    end else if (ar_addr_r == ptm_pkg::ADDR_CNT_LO) begin
      rbyte = cnt16[7:0];
    end else if (ar_addr_r == ptm_pkg::ADDR_CNT_HI) begin
      rbyte = cnt16[15:8];
    end else if (ar_addr_r == ptm_pkg::ADDR_DUTY_LO) begin
      rbyte = duty16[7:0];
    end else if (ar_addr_r == ptm_pkg::ADDR_DUTY_HI) begin
      rbyte = duty16[15:8];
    end else if (ar_addr_r == ptm_pkg::ADDR_PER_LO) begin
      rbyte = per16[7:0];
    end else if (ar_addr_r == ptm_pkg::ADDR_PER_HI) begin
      rbyte = per16[15:8];
    end else if (ar_addr_r == ptm_pkg::ADDR_FLAGS) begin
      rbyte = {6'h00, flag_p_r, flag_a_r};
    end else begin
      rbyte = 8'h00;
      rerr = 1'b1;
    end
  end
  logic ar_pend_r;
  assign s_axi_arready = ~ar_pend_r & ~s_axi_rvalid;

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      aw_ok_r <= 1'b0;
      w_ok_r <= 1'b0;
      aw_addr_r <= 6'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ptm_pkg::RESP_OKAY;
      ar_pend_r <= 1'b0;
      ar_addr_r <= 6'h00;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ptm_pkg::RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_ok_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        w_ok_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_ok_r <= 1'b0;
        w_ok_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= aw_mapped ? ptm_pkg::RESP_OKAY : ptm_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid & s_axi_arready) begin
        ar_pend_r <= 1'b1;
        ar_addr_r <= s_axi_araddr;
      end
      if (ar_pend_r) begin
        ar_pend_r <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rbyte};
        s_axi_rresp <= rerr ? ptm_pkg::RESP_SLVERR : ptm_pkg::RESP_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Timer state
  // ****************************************************************
  // A match in the same cycle as a software clear keeps its flag set.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      c0_r <= ptm_pkg::CTRL_RESET[ptm_pkg::PAUSE_BIT:ptm_pkg::RUN_BIT];
      c1_r <= ptm_pkg::CTRL_RESET;
      cnt_r <= CNT_ZERO;
      duty_r <= CNT_ZERO;
      per_r <= CNT_ZERO;
      flag_a_r <= 1'b0;
      flag_p_r <= 1'b0;
      pin_r <= 1'b0;
      run_d_r <= 1'b0;
    end else begin
      if (wr_c0) begin
        c0_r <= wb[ptm_pkg::PAUSE_BIT:ptm_pkg::RUN_BIT];
      end else if (single & evt_a) begin
        c0_r.run <= 1'b0;
      end
      if (wr_c1) begin
        c1_r <= wb;
      end
      cnt_r <= cnt_nxt;
      duty_r <= duty_nxt;
      per_r <= per_nxt;
      flag_a_r <= (evt_a | capture) | (flag_a_r & ~(wr_fl & wb[0]));
      flag_p_r <= evt_p | (flag_p_r & ~(wr_fl & wb[1]));
      pin_r <= pin_nxt;
      run_d_r <= c0_r.run;
    end
  end

endmodule
